// ==== verilog/oedf_top.sv ====
// output edge delay filter: terminal and relay outputs with run status
`timescale 1ns/100ps
`default_nettype none

// Function
// - delays programmable from 0 to 100 s in 0.1 s steps
// - rise and fall delays set independently per output
// - turn-on output only after source held for the on delay, less up to one 0.1 s tick
// - source pulses shorter than on delay are dropped
// - off delay stretches each pulse by the off time
// - source gaps shorter than off delay are bridged
// - both delays together shift both edges, short pulses still dropped
// - terminal output has own rise and fall delays, 0 to 100 s, default 0
// - relay has own rise and fall delays, up to 100 s, default 0
// - delays apply to any assigned function; zero passes directly
// - function code 00 drives output on in run, off in stop
// - terminal output active low, transistor pulls to ground when on
// - run status asserted while output frequency exceeds start frequency
module oedf_top #(
  parameter int unsigned TICK_CYCLES = oedf_pkg::TICK_CYCLES  // clocks per 0.1 s
) (
  input  wire logic                        clk_sys,      // system clock, 10 MHz
  input  wire logic                        rst,          // async reset, active high
  input  wire logic [oedf_pkg::ADDR_W-1:0] reg_addr,     // register byte address
  input  wire logic [oedf_pkg::DATA_W-1:0] reg_wdata,    // register write data
  input  wire logic                        reg_wr,       // write strobe
  input  wire logic                        reg_rd,       // read strobe
  output logic      [oedf_pkg::DATA_W-1:0] reg_rdata,    // read data, cycle after strobe
  input  wire logic [oedf_pkg::FREQ_W-1:0] out_freq,     // present output frequency
  input  wire logic                        alarm_in,     // alarm function source
  input  wire logic [oedf_pkg::NUM_SRC-1:0] aux_func,    // other function sources by code
  output logic                             term_pin_o,   // terminal pin level when driven
  output logic                             term_pin_oe,  // terminal transistor on
  output logic                             relay_coil,   // relay coil energised
  output logic                             run_status    // running indication
);

  localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam int unsigned DW = oedf_pkg::DLY_W;

  // limit a written delay to the 100 s ceiling
  function automatic logic [DW-1:0] clamp_dly(input logic [oedf_pkg::DATA_W-1:0] v);
    logic [DW-1:0] r;
    r = oedf_pkg::DLY_MAX;
    if (v < {22'h000000, oedf_pkg::DLY_MAX})
    begin
      r = v[DW-1:0];
    end
    return r;
  endfunction

  // pick the source for an output function code; unknown codes read as off
  function automatic logic pick_source(input logic [oedf_pkg::FUNC_W-1:0] code,
                                       input logic [oedf_pkg::NUM_SRC-1:0] srcs);
    logic r;
    r = 1'b0;
    if (code < oedf_pkg::FUNC_W'(oedf_pkg::NUM_SRC))
    begin
      r = srcs[code[2:0]];
    end
    return r;
  endfunction

  // configuration registers
  logic [DW-1:0]                 term_out_rise_delay_q;
  logic [DW-1:0]                 term_out_rise_delay_d;
  logic [DW-1:0]                 term_out_fall_delay_q;
  logic [DW-1:0]                 term_out_fall_delay_d;
  logic [DW-1:0]                 relay_rise_delay_q;
  logic [DW-1:0]                 relay_rise_delay_d;
  logic [DW-1:0]                 relay_fall_delay_q;
  logic [DW-1:0]                 relay_fall_delay_d;
  logic [oedf_pkg::FUNC_W-1:0]   term_func_q;
  logic [oedf_pkg::FUNC_W-1:0]   term_func_d;
  logic [oedf_pkg::FUNC_W-1:0]   relay_func_q;
  logic [oedf_pkg::FUNC_W-1:0]   relay_func_d;
  logic [oedf_pkg::FREQ_W-1:0]   start_frequency_setting_q;
  logic [oedf_pkg::FREQ_W-1:0]   start_frequency_setting_d;
  logic [oedf_pkg::DATA_W-1:0]   rdata_q;
  logic [oedf_pkg::DATA_W-1:0]   rdata_d;

  // time base and source state
  logic [TW-1:0]                 tick_cnt_q;
  logic [TW-1:0]                 tick_cnt_d;
  logic                          tick_q;
  logic                          tick_d;
  logic                          run_q;
  logic                          run_d;
  logic                          term_src_q;
  logic                          term_src_d;
  logic                          relay_src_q;
  logic                          relay_src_d;
  logic [oedf_pkg::NUM_SRC-1:0]  src_vec;
  logic                          term_on;
  logic                          relay_on;

  // register writes; every delay write is clamped so a bad value cannot exceed 100 s
  always_comb
  begin
    term_out_rise_delay_d     = term_out_rise_delay_q;
    term_out_fall_delay_d     = term_out_fall_delay_q;
    relay_rise_delay_d        = relay_rise_delay_q;
    relay_fall_delay_d        = relay_fall_delay_q;
    term_func_d               = term_func_q;
    relay_func_d              = relay_func_q;
    start_frequency_setting_d = start_frequency_setting_q;
    if (reg_wr)
    begin
      case (reg_addr)
        oedf_pkg::OFS_TERM_RISE:  term_out_rise_delay_d = clamp_dly(reg_wdata);
        oedf_pkg::OFS_TERM_FALL:  term_out_fall_delay_d = clamp_dly(reg_wdata);
        oedf_pkg::OFS_RELAY_RISE: relay_rise_delay_d    = clamp_dly(reg_wdata);
        oedf_pkg::OFS_RELAY_FALL: relay_fall_delay_d    = clamp_dly(reg_wdata);
        oedf_pkg::OFS_TERM_FUNC:  term_func_d  = reg_wdata[oedf_pkg::FUNC_W-1:0];
        oedf_pkg::OFS_RELAY_FUNC: relay_func_d = reg_wdata[oedf_pkg::FUNC_W-1:0];
        oedf_pkg::OFS_START_FREQ:
          start_frequency_setting_d = reg_wdata[oedf_pkg::FREQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses and reserved bits read as zero
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        oedf_pkg::OFS_TERM_RISE:  rdata_d[DW-1:0] = term_out_rise_delay_q;
        oedf_pkg::OFS_TERM_FALL:  rdata_d[DW-1:0] = term_out_fall_delay_q;
        oedf_pkg::OFS_RELAY_RISE: rdata_d[DW-1:0] = relay_rise_delay_q;
        oedf_pkg::OFS_RELAY_FALL: rdata_d[DW-1:0] = relay_fall_delay_q;
        oedf_pkg::OFS_TERM_FUNC:  rdata_d[oedf_pkg::FUNC_W-1:0] = term_func_q;
        oedf_pkg::OFS_RELAY_FUNC: rdata_d[oedf_pkg::FUNC_W-1:0] = relay_func_q;
        oedf_pkg::OFS_START_FREQ: rdata_d[oedf_pkg::FREQ_W-1:0] = start_frequency_setting_q;
        oedf_pkg::OFS_STATUS:
        begin
          rdata_d[oedf_pkg::ST_TERM_BIT]  = term_on;
          rdata_d[oedf_pkg::ST_RELAY_BIT] = relay_on;
          rdata_d[oedf_pkg::ST_RUN_BIT]   = run_q;
          rdata_d[oedf_pkg::ST_TSRC_BIT]  = term_src_q;
          rdata_d[oedf_pkg::ST_RSRC_BIT]  = relay_src_q;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // 0.1 s time base shared by both channels; the first tick of a delay may come
  // early by up to one period, the price of not running a prescaler per channel
  always_comb
  begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 1'b1;
    if (tick_cnt_q == TICK_LAST)
    begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
  end

  // running indication and function selection
  always_comb
  begin
    run_d = (out_freq > start_frequency_setting_q);
    src_vec = aux_func;
    src_vec[oedf_pkg::FUNC_RUN[2:0]]   = run_q;
    src_vec[oedf_pkg::FUNC_ALARM[2:0]] = alarm_in;
    term_src_d  = pick_source(term_func_q, src_vec);
    relay_src_d = pick_source(relay_func_q, src_vec);
  end

  // all top-level state; channel output and counter state sits in the oedf_edge_delay instances
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      term_out_rise_delay_q     <= oedf_pkg::DLY_RST;
      term_out_fall_delay_q     <= oedf_pkg::DLY_RST;
      relay_rise_delay_q        <= oedf_pkg::DLY_RST;
      relay_fall_delay_q        <= oedf_pkg::DLY_RST;
      term_func_q               <= oedf_pkg::TERM_FUNC_RST;
      relay_func_q              <= oedf_pkg::RELAY_FUNC_RST;
      start_frequency_setting_q <= oedf_pkg::START_FREQ_RST;
      rdata_q                   <= '0;
      tick_cnt_q                <= '0;
      tick_q                    <= 1'b0;
      run_q                     <= 1'b0;
      term_src_q                <= 1'b0;
      relay_src_q               <= 1'b0;
    end
    else
    begin
      term_out_rise_delay_q     <= term_out_rise_delay_d;
      term_out_fall_delay_q     <= term_out_fall_delay_d;
      relay_rise_delay_q        <= relay_rise_delay_d;
      relay_fall_delay_q        <= relay_fall_delay_d;
      term_func_q               <= term_func_d;
      relay_func_q              <= relay_func_d;
      start_frequency_setting_q <= start_frequency_setting_d;
      rdata_q                   <= rdata_d;
      tick_cnt_q                <= tick_cnt_d;
      tick_q                    <= tick_d;
      run_q                     <= run_d;
      term_src_q                <= term_src_d;
      relay_src_q               <= relay_src_d;
    end
  end

  // terminal channel
  oedf_edge_delay #(
    .DW      (DW)
  ) u_term (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick_q),
    .src     (term_src_q),
    .on_dly  (term_out_rise_delay_q),
    .off_dly (term_out_fall_delay_q),
    .out_q   (term_on)
  );

  // relay channel, settings kept apart from the terminal
  oedf_edge_delay #(
    .DW      (DW)
  ) u_relay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick_q),
    .src     (relay_src_q),
    .on_dly  (relay_rise_delay_q),
    .off_dly (relay_fall_delay_q),
    .out_q   (relay_on)
  );

  // open collector: the pin only ever sinks, so its level is fixed low and the
  // enable carries the signal
  assign term_pin_o  = 1'b0;
  assign term_pin_oe = term_on;
  assign relay_coil  = relay_on;
  assign run_status  = run_q;
  assign reg_rdata   = rdata_q;

  // configuration bounds: every delay stays under the ceiling, an oversized write saturates
  a_delay_clamped : assert property (@(posedge clk_sys) disable iff (rst)
    term_out_rise_delay_q <= oedf_pkg::DLY_MAX && term_out_fall_delay_q <= oedf_pkg::DLY_MAX &&
    relay_rise_delay_q <= oedf_pkg::DLY_MAX && relay_fall_delay_q <= oedf_pkg::DLY_MAX)
    else $error("delay above ceiling");
  a_write_saturates : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == oedf_pkg::OFS_TERM_RISE && reg_wdata > {22'h000000, oedf_pkg::DLY_MAX})
    |=> term_out_rise_delay_q == oedf_pkg::DLY_MAX) else $error("oversized delay not saturated");
  a_relay_apart : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == oedf_pkg::OFS_TERM_RISE) |=>
    $stable(relay_rise_delay_q) && $stable(relay_fall_delay_q))
    else $error("terminal write moved relay delay");
  a_run_follows_freq : assert property (@(posedge clk_sys) disable iff (rst)
    (out_freq > start_frequency_setting_q) |=> run_q) else $error("run status missed");
  a_stop_clears_run : assert property (@(posedge clk_sys) disable iff (rst)
    (out_freq <= start_frequency_setting_q) |=> !run_q) else $error("run status stuck");
  a_oc_sinks_only : assert property (@(posedge clk_sys) disable iff (rst)
    term_pin_oe |-> !term_pin_o) else $error("terminal driven high");
  a_tick_spacing : assert property (@(posedge clk_sys) disable iff (rst)
    tick_q |=> !tick_q) else $error("ticks back to back");
  // read port: data stands one cycle only, holes read as zero
  a_unmapped_zero : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr[1:0] != 2'h0) |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_rdata_one_cycle : assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata == '0) else $error("read data held too long");
  a_read_rise_dly : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == oedf_pkg::OFS_TERM_RISE) |=>
    reg_rdata[DW-1:0] == term_out_rise_delay_q) else $error("delay readback wrong");
  a_status_run : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == oedf_pkg::OFS_STATUS) |=>
    reg_rdata[oedf_pkg::ST_RUN_BIT] == $past(run_q)) else $error("status run bit wrong");
  // function routing into the channels
  a_run_src_to_term : assert property (@(posedge clk_sys) disable iff (rst)
    (term_func_q == oedf_pkg::FUNC_RUN && $stable(term_func_q)) |=> term_src_q == $past(run_q))
    else $error("run function not routed");
  a_alarm_to_relay : assert property (@(posedge clk_sys) disable iff (rst)
    (relay_func_q == oedf_pkg::FUNC_ALARM && $stable(relay_func_q)) |=>
    relay_src_q == $past(alarm_in)) else $error("alarm function not routed");

  // main scenarios that a run should reach
  c_run_on : cover property (@(posedge clk_sys) disable iff (rst) $rose(run_q));
  c_term_on : cover property (@(posedge clk_sys) disable iff (rst) $rose(term_pin_oe));
  c_relay_off : cover property (@(posedge clk_sys) disable iff (rst) $fell(relay_coil));

endmodule

`default_nettype wire

// ==== verilog/oedf_pkg.sv ====
// constants shared by the output edge delay filter block
package oedf_pkg;

  // delay settings are held in tenths of a second
  localparam int unsigned DLY_W     = 10;
  localparam logic [9:0]  DLY_MAX   = 10'h3E8;   // 100.0 s in 0.1 s steps
  localparam logic [9:0]  DLY_RST   = 10'h000;   // 0.0 s after reset

  // time base: one tick every 0.1 s at a 100 ns clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 100_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // register bus
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam logic [4:0]  OFS_TERM_RISE  = 5'h00;
  localparam logic [4:0]  OFS_TERM_FALL  = 5'h04;
  localparam logic [4:0]  OFS_RELAY_RISE = 5'h08;
  localparam logic [4:0]  OFS_RELAY_FALL = 5'h0C;
  localparam logic [4:0]  OFS_TERM_FUNC  = 5'h10;
  localparam logic [4:0]  OFS_RELAY_FUNC = 5'h14;
  localparam logic [4:0]  OFS_START_FREQ = 5'h18;
  localparam logic [4:0]  OFS_STATUS     = 5'h1C;

  // output function codes
  localparam int unsigned FUNC_W      = 8;
  localparam logic [7:0]  FUNC_RUN    = 8'h00;
  localparam logic [7:0]  FUNC_ALARM  = 8'h05;
  localparam logic [7:0]  TERM_FUNC_RST  = 8'h00;
  localparam logic [7:0]  RELAY_FUNC_RST = 8'h05;
  localparam int unsigned NUM_SRC     = 8;

  // output frequency word
  localparam int unsigned FREQ_W        = 16;
  localparam logic [15:0] START_FREQ_RST = 16'h0000;

  // status register bit positions
  localparam int unsigned ST_TERM_BIT  = 0;
  localparam int unsigned ST_RELAY_BIT = 1;
  localparam int unsigned ST_RUN_BIT   = 2;
  localparam int unsigned ST_TSRC_BIT  = 3;
  localparam int unsigned ST_RSRC_BIT  = 4;

endpackage

// ==== verilog/oedf_edge_delay.sv ====
// one output channel: independent turn-on and turn-off delay filter
`timescale 1ns/100ps
`default_nettype none

module oedf_edge_delay #(
  parameter int unsigned DW = oedf_pkg::DLY_W
) (
  input  wire logic          clk_sys,  // system clock
  input  wire logic          rst,      // async reset, active high
  input  wire logic          tick,     // 0.1 s time base pulse
  input  wire logic          src,      // unfiltered source signal
  input  wire logic [DW-1:0] on_dly,   // turn-on delay in ticks
  input  wire logic [DW-1:0] off_dly,  // turn-off delay in ticks
  output logic               out_q     // filtered output
);

  logic [DW-1:0] cnt_q;
  logic [DW-1:0] cnt_d;
  logic          out_d;
  logic [DW-1:0] want;

  // pending delay: count ticks while the source disagrees with the output
  always_comb
  begin
    want  = out_q ? off_dly : on_dly;
    out_d = out_q;
    cnt_d = cnt_q;
    if (src == out_q)
    begin
      cnt_d = '0;
    end
    else if (want == '0)
    begin
      out_d = src;
      cnt_d = '0;
    end
    else if (tick)
    begin
      if (cnt_q + 1'b1 >= want)
      begin
        out_d = src;
        cnt_d = '0;
      end
      else
      begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  // the output only moves toward the source: a rise needs a source that was high
  a_rise_needs_src : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(out_q) |-> $past(src)) else $error("output rose without source");
  a_fall_needs_low : assert property (@(posedge clk_sys) disable iff (rst)
    $fell(out_q) |-> !$past(src)) else $error("output fell with source high");
  a_zero_on_pass : assert property (@(posedge clk_sys) disable iff (rst)
    (!out_q && src && on_dly == '0) |=> out_q) else $error("zero on delay not passed");
  a_zero_off_pass : assert property (@(posedge clk_sys) disable iff (rst)
    (out_q && !src && off_dly == '0) |=> !out_q) else $error("zero off delay not passed");
  a_no_tick_hold : assert property (@(posedge clk_sys) disable iff (rst)
    (!tick && on_dly != '0 && off_dly != '0) |=> $stable(out_q))
    else $error("output moved without a tick");
  a_count_restart : assert property (@(posedge clk_sys) disable iff (rst)
    (src == out_q) |=> cnt_q == '0) else $error("count not restarted");
  c_delayed_rise : cover property (@(posedge clk_sys) disable iff (rst)
    $rose(out_q) && on_dly != '0);
  c_pulse_dropped : cover property (@(posedge clk_sys) disable iff (rst)
    !out_q && cnt_q != '0 ##1 !src);

endmodule

`default_nettype wire

// ==== tb/oedf_load.sv ====
// external load model: pulled-up collector line and relay contact set
`timescale 1ns/100ps
`default_nettype none

module oedf_load (
  input  wire logic term_pin_o,    // terminal drive level from the block
  input  wire logic term_pin_oe,   // terminal transistor on
  input  wire logic relay_coil,    // relay coil energised
  output logic      term_line,     // level seen on the wired terminal
  output logic      relay_closed   // normally open contact closed
);
  // released collector floats up to the external supply, so never keep the old level
  assign term_line = term_pin_oe ? term_pin_o : 1'b1;
  // contact follows the coil directly; bounce is not modelled
  assign relay_closed = relay_coil;
endmodule

`default_nettype wire

// ==== tb/output_edge_delay_filter_tb.sv ====
// self-checking bench for the output edge delay filter
`timescale 1ns/100ps
`default_nettype none

module output_edge_delay_filter_tb;
  localparam int T = 4;  // clocks per tick, kept short for simulation

  logic        clk_sys;
  logic        rst;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [15:0] out_freq;
  logic        alarm_in;
  logic [7:0]  aux_func;
  logic        term_pin_o;
  logic        term_pin_oe;
  logic        relay_coil;
  logic        run_status;
  logic        term_line;
  logic        relay_closed;
  int          err_count;
  int          n_compared;

  oedf_top #(.TICK_CYCLES(T)) oedf_top_inst (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .out_freq   (out_freq),
    .alarm_in   (alarm_in),
    .aux_func   (aux_func),
    .term_pin_o (term_pin_o),
    .term_pin_oe(term_pin_oe),
    .relay_coil (relay_coil),
    .run_status (run_status)
  );

  oedf_load oedf_load_inst (
    .term_pin_o  (term_pin_o),
    .term_pin_oe (term_pin_oe),
    .relay_coil  (relay_coil),
    .term_line   (term_line),
    .relay_closed(relay_closed)
  );

  // 10 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one write cycle; strobe dropped at the following edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata, exp);
  endtask

  // channel 0 is the terminal (on when line pulled low), 1 is the relay
  function automatic logic outv(input int which);
    return (which == 0) ? ~term_line : relay_closed;
  endfunction

  // sources for both channels come from aux_func bits 3 and 4
  task automatic drive(input int which, input logic v);
    @(posedge clk_sys);
    aux_func[3+which] <= v;
  endtask

  task automatic quiet(input int which, input logic lvl, input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      check({31'h0, outv(which)}, {31'h0, lvl});
    end
  endtask

  // counts whole-cycle samples, one per falling edge, until the channel reaches lvl, then checks the window
  task automatic measure(input int which, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (n <= hi + 1)
    begin
      @(negedge clk_sys);
      if (outv(which) === lvl)
        break;
      n++;
    end
    check({31'h0, n >= lo && n <= hi}, 32'h0000_0001);
  endtask

  // bounded run: far longer than the whole sequence needs
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    close_out();
  end

  initial
  begin
    logic [31:0] rv [8];
    int i;
    rv = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5, 32'h0, 32'h0};
    err_count  = 0;
    n_compared = 0;
    rst = 1'b1; reg_addr = 5'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    out_freq = 16'h0000; alarm_in = 1'b0; aux_func = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values of every register, and an unaligned hole
    for (i = 0; i < 8; i++)
      rd(5'(i * 4), rv[i]);
    rd(5'h02, 32'h0);
    // delay settings saturate at 100.0 s
    wr(oedf_pkg::OFS_TERM_RISE, 32'h0000_07FF);
    rd(oedf_pkg::OFS_TERM_RISE, 32'h0000_03E8);
    wr(oedf_pkg::OFS_TERM_RISE, 32'h0000_0000);
    // run signal on the terminal, alarm on the relay, zero delays
    wr(oedf_pkg::OFS_START_FREQ, 32'h0000_0100);
    @(posedge clk_sys);
    out_freq <= 16'h0100;
    repeat (6) @(negedge clk_sys);
    check({31'h0, run_status}, 32'h0);
    @(posedge clk_sys);
    out_freq <= 16'h0101;
    measure(0, 1'b1, 3, 3);
    check({31'h0, run_status}, 32'h1);
    check({31'h0, term_pin_o}, 32'h0);
    @(posedge clk_sys);
    alarm_in <= 1'b1;
    measure(1, 1'b1, 2, 2);
    rd(oedf_pkg::OFS_STATUS, 32'h0000_001F);
    @(posedge clk_sys);
    out_freq <= 16'h0000;
    alarm_in <= 1'b0;
    measure(0, 1'b0, 3, 3);
    // terminal on function 3 with 0.3 s turn-on delay
    wr(oedf_pkg::OFS_TERM_FUNC, 32'h0000_0003);
    wr(oedf_pkg::OFS_TERM_RISE, 32'h0000_0003);
    for (i = 0; i < 3; i++)
    begin
      drive(0, 1'b1);
      quiet(0, 1'b0, 7);
      drive(0, 1'b0);
      quiet(0, 1'b0, 1);
    end
    quiet(0, 1'b0, 6);
    drive(0, 1'b1);
    measure(0, 1'b1, 2 + 2 * T, 1 + 3 * T);
    drive(0, 1'b0);
    measure(0, 1'b0, 2, 2);
    // relay on function 4 with 0.2 s turn-off delay only
    wr(oedf_pkg::OFS_RELAY_FUNC, 32'h0000_0004);
    wr(oedf_pkg::OFS_RELAY_FALL, 32'h0000_0002);
    drive(1, 1'b1);
    measure(1, 1'b1, 2, 2);
    drive(1, 1'b0);
    quiet(1, 1'b1, 3);
    drive(1, 1'b1);
    quiet(1, 1'b1, 10);
    drive(1, 1'b0);
    measure(1, 1'b0, 2 + T, 1 + 2 * T);
    // both delays on the terminal
    wr(oedf_pkg::OFS_TERM_FALL, 32'h0000_0002);
    drive(0, 1'b1);
    quiet(0, 1'b0, 6);
    drive(0, 1'b0);
    quiet(0, 1'b0, 20);
    drive(0, 1'b1);
    measure(0, 1'b1, 2 + 2 * T, 1 + 3 * T);
    quiet(0, 1'b1, 4);
    drive(0, 1'b0);
    measure(0, 1'b0, 2 + T, 1 + 2 * T);
    rd(oedf_pkg::OFS_TERM_FALL, 32'h0000_0002);
    // function codes past the last source read as off, the relay still follows code 4
    @(posedge clk_sys);
    aux_func <= 8'hFF;
    wr(oedf_pkg::OFS_TERM_FUNC, 32'h0000_0008);
    rd(oedf_pkg::OFS_STATUS, 32'h0000_0012);
    close_out();
  end
endmodule

`default_nettype wire
